/* File: hw/tcm_top.v */
// Channel mode control of one timer: channel-1 compare output, channel-2
// input selection and the register port that software uses to steer them.
// Assumes the counter, its direction and the filtered channel signals come
// from timer logic on the same clock; no synchroniser is placed on them.
`timescale 1ns/1ps
`include "tcm_defines.vh"

module tcm_top (
    input  wire        clock_i,
    input  wire        resetn_i,
    // Register port
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_write_i,
    input  wire        reg_read_i,
    output reg  [31:0] reg_rdata_o,
    // Counter side
    input  wire [15:0] counter_value_i,
    input  wire        count_down_i,
    // Channel inputs
    input  wire        ch2_filtered_signal_i,
    input  wire        ch1_filtered_signal_to_ch2_i,
    input  wire        slave_trigger_input_i,
    // Channel outputs
    output reg         ch1_raw_compare_level_o,
    output reg         ch1_final_output_o,
    output reg         ch1_output_connected_o,
    output reg         ch2_input_source_o,
    output reg         ch2_is_input_o
);
    // Software state
    reg  [2:0]  ch1_output_mode_field_r;
    reg  [1:0]  ch2_direction_select_r;
    reg         ch1_polarity_r;
    reg         ch2_enable_bit_r;
    reg  [2:0]  trigger_source_select_r;
    reg  [15:0] ch1_compare_value_r;
    reg         match_seen_r;
    reg  [15:0] match_count_r;
    reg         trig_mode_bad_r;

    // Decode
    wire        sel_mode;
    wire        sel_ctrl;
    wire        sel_cmp;
    wire        sel_status;
    wire        sel_mcnt;
    wire        wr_mode;
    wire        wr_ctrl;
    wire        wr_cmp;
    wire        wr_status;
    wire        wr_mcnt;

    // Datapath
    wire        level_nxt;
    wire        match;
    wire        connected;
    wire        final_nxt;
    wire        trigger_internal;
    wire        ch2_sel_source;
    wire        ch2_sel_is_input;
    wire        ch2_sel_trig_bad;
    wire        match_event;
    reg  [31:0] rdata_nxt;

    assign sel_mode   = (reg_addr_i == `TCM_OFS_MODE);
    assign sel_ctrl   = (reg_addr_i == `TCM_OFS_CTRL);
    assign sel_cmp    = (reg_addr_i == `TCM_OFS_CMP);
    assign sel_status = (reg_addr_i == `TCM_OFS_STATUS);
    assign sel_mcnt   = (reg_addr_i == `TCM_OFS_MATCH_CNT);
    assign wr_mode    = reg_write_i && sel_mode;
    assign wr_ctrl    = reg_write_i && sel_ctrl;
    assign wr_cmp     = reg_write_i && sel_cmp;
    assign wr_status  = reg_write_i && sel_status;
    assign wr_mcnt    = reg_write_i && sel_mcnt;

    assign trigger_internal = (trigger_source_select_r < `TCM_TRIG_INTERNAL_LIM);

    // Compare evaluation every clock against the registered compare value
    tcm_compare tcm_compare_i (
        .ch1_output_mode_field_i (ch1_output_mode_field_r),
        .counter_value_i         (counter_value_i),
        .ch1_compare_value_i     (ch1_compare_value_r),
        .count_down_i            (count_down_i),
        .level_i                 (ch1_raw_compare_level_o),
        .level_nxt_o             (level_nxt),
        .match_o                 (match)
    );

    tcm_ch2_select tcm_ch2_select_i (
        .ch2_direction_select_i       (ch2_direction_select_r),
        .ch2_filtered_signal_i        (ch2_filtered_signal_i),
        .ch1_filtered_signal_to_ch2_i (ch1_filtered_signal_to_ch2_i),
        .slave_trigger_input_i        (slave_trigger_input_i),
        .trigger_internal_i           (trigger_internal),
        .ch2_input_source_o           (ch2_sel_source),
        .ch2_is_input_o               (ch2_sel_is_input),
        .trig_mode_bad_o              (ch2_sel_trig_bad)
    );

    // Output is attached to the raw level for every mode but disconnect
    assign connected = (ch1_output_mode_field_r != `TCM_OM_DISCONNECT);
    // Detached output rests at the inactive level after polarity
    assign final_nxt = connected ? (level_nxt ^ ch1_polarity_r)
                                 : ch1_polarity_r;

    // Only compare-driven modes count matches as events
    assign match_event = match && connected
                         && (ch1_output_mode_field_r != `TCM_OM_FORCE_LOW)
                         && (ch1_output_mode_field_r != `TCM_OM_FORCE_HIGH);

    // Mode register
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            ch1_output_mode_field_r <= `TCM_RST_CH1_MODE;
            ch2_direction_select_r  <= `TCM_RST_CH2_DIR;
        end else if (wr_mode) begin
            ch1_output_mode_field_r <=
                reg_wdata_i[`TCM_MODE_CH1_MSB:`TCM_MODE_CH1_LSB];
            // Direction is frozen while channel 2 is enabled
            if (!ch2_enable_bit_r) begin
                ch2_direction_select_r <=
                    reg_wdata_i[`TCM_MODE_CH2_MSB:`TCM_MODE_CH2_LSB];
            end
        end
    end

    // Control register
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            ch1_polarity_r          <= 1'b0;
            ch2_enable_bit_r        <= 1'b0;
            trigger_source_select_r <= `TCM_RST_TRIG_SEL;
        end else if (wr_ctrl) begin
            ch1_polarity_r          <= reg_wdata_i[`TCM_CTRL_POL_BIT];
            ch2_enable_bit_r        <= reg_wdata_i[`TCM_CTRL_CH2EN_BIT];
            trigger_source_select_r <=
                reg_wdata_i[`TCM_CTRL_TRIG_MSB:`TCM_CTRL_TRIG_LSB];
        end
    end

    // Compare value register
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            ch1_compare_value_r <= `TCM_RST_CMP;
        end else if (wr_cmp) begin
            ch1_compare_value_r <= reg_wdata_i[15:0];
        end
    end

    // Sticky match flag: a new match wins over a clear in the same cycle
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            match_seen_r <= 1'b0;
        end else if (match_event) begin
            match_seen_r <= 1'b1;
        end else if (wr_status && reg_wdata_i[`TCM_ST_MATCH_BIT]) begin
            match_seen_r <= 1'b0;
        end
    end

    // Match counter: any write clears it, a match in that cycle counts as one
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            match_count_r <= 16'h0000;
        end else if (wr_mcnt) begin
            match_count_r <= {15'h0000, match_event};
        end else if (match_event && (match_count_r != 16'hFFFF)) begin
            match_count_r <= match_count_r + 16'h0001;
        end
    end

    // Channel outputs
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            ch1_raw_compare_level_o <= 1'b0;
            ch1_final_output_o      <= 1'b0;
            ch1_output_connected_o  <= 1'b0;
            ch2_input_source_o      <= 1'b0;
            ch2_is_input_o          <= 1'b0;
            trig_mode_bad_r         <= 1'b0;
        end else begin
            ch1_raw_compare_level_o <= level_nxt;
            ch1_final_output_o      <= final_nxt;
            ch1_output_connected_o  <= connected;
            ch2_input_source_o      <= ch2_sel_source;
            ch2_is_input_o          <= ch2_sel_is_input;
            trig_mode_bad_r         <= ch2_sel_trig_bad;
        end
    end

    // Read data mux; reserved bit 7 of the mode register reads zero
    always @* begin
        rdata_nxt = 32'h00000000;
        if (sel_mode) begin
            rdata_nxt[`TCM_MODE_CH1_MSB:`TCM_MODE_CH1_LSB] = ch1_output_mode_field_r;
            rdata_nxt[`TCM_MODE_RSVD_BIT] = 1'b0;
            rdata_nxt[`TCM_MODE_CH2_MSB:`TCM_MODE_CH2_LSB] = ch2_direction_select_r;
        end else if (sel_ctrl) begin
            rdata_nxt[`TCM_CTRL_POL_BIT]   = ch1_polarity_r;
            rdata_nxt[`TCM_CTRL_CH2EN_BIT] = ch2_enable_bit_r;
            rdata_nxt[`TCM_CTRL_TRIG_MSB:`TCM_CTRL_TRIG_LSB] = trigger_source_select_r;
        end else if (sel_cmp) begin
            rdata_nxt[15:0] = ch1_compare_value_r;
        end else if (sel_status) begin
            rdata_nxt[`TCM_ST_RAW_BIT]     = ch1_raw_compare_level_o;
            rdata_nxt[`TCM_ST_OUT_BIT]     = ch1_final_output_o;
            rdata_nxt[`TCM_ST_MATCH_BIT]   = match_seen_r;
            rdata_nxt[`TCM_ST_CH2IN_BIT]   = ch2_input_source_o;
            rdata_nxt[`TCM_ST_TRIGBAD_BIT] = trig_mode_bad_r;
        end else if (sel_mcnt) begin
            rdata_nxt[15:0] = match_count_r;
        end
    end

    // Read data stands for exactly the cycle after the read strobe
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_read_i) begin
            reg_rdata_o <= rdata_nxt;
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end
endmodule

/* File: hw/tcm_defines.vh */
// Constants for the timer channel compare output mode block.
// Included by every design file of the block; holds definitions only.
`ifndef TCM_DEFINES_VH
`define TCM_DEFINES_VH

// Register byte offsets
`define TCM_OFS_MODE          8'h00
`define TCM_OFS_CTRL          8'h04
`define TCM_OFS_CMP           8'h08
`define TCM_OFS_STATUS        8'h0C
`define TCM_OFS_MATCH_CNT     8'h10

// Mode register fields
`define TCM_MODE_CH1_LSB      4
`define TCM_MODE_CH1_MSB      6
`define TCM_MODE_RSVD_BIT     7
`define TCM_MODE_CH2_LSB      8
`define TCM_MODE_CH2_MSB      9

// Control register fields
`define TCM_CTRL_POL_BIT      0
`define TCM_CTRL_CH2EN_BIT    1
`define TCM_CTRL_TRIG_LSB     4
`define TCM_CTRL_TRIG_MSB     6

// Status register fields
`define TCM_ST_RAW_BIT        0
`define TCM_ST_OUT_BIT        1
`define TCM_ST_MATCH_BIT      2
`define TCM_ST_CH2IN_BIT      3
`define TCM_ST_TRIGBAD_BIT    4

// Reset values
`define TCM_RST_CH1_MODE      3'h0
`define TCM_RST_CH2_DIR       2'h0
`define TCM_RST_TRIG_SEL      3'h0
`define TCM_RST_CMP           16'h0000

// Channel-1 output modes
`define TCM_OM_DISCONNECT     3'h0
`define TCM_OM_HIGH_ON_MATCH  3'h1
`define TCM_OM_LOW_ON_MATCH   3'h2
`define TCM_OM_TOGGLE         3'h3
`define TCM_OM_FORCE_LOW      3'h4
`define TCM_OM_FORCE_HIGH     3'h5
`define TCM_OM_PWM_A          3'h6
`define TCM_OM_PWM_B          3'h7

// Channel-2 direction codes
`define TCM_DIR_OUTPUT        2'h0
`define TCM_DIR_IN_OWN        2'h1
`define TCM_DIR_IN_CH1        2'h2
`define TCM_DIR_IN_TRIG       2'h3

// Trigger select codes below this value name an internal source
`define TCM_TRIG_INTERNAL_LIM 3'h4

`endif

/* File: hw/tcm_compare.v */
// Next-level logic for the channel-1 raw compare level.
// Assumes counter and compare value are on the timer counter clock.
`timescale 1ns/1ps
`include "tcm_defines.vh"

module tcm_compare (
    input  wire [2:0]  ch1_output_mode_field_i,
    input  wire [15:0] counter_value_i,
    input  wire [15:0] ch1_compare_value_i,
    input  wire        count_down_i,
    input  wire        level_i,
    output reg         level_nxt_o,
    output wire        match_o
);
    wire cmp_gt_cnt;
    wire cmp_lt_cnt;
    wire pwm_a_level;

    assign match_o     = (counter_value_i == ch1_compare_value_i);
    assign cmp_gt_cnt  = (ch1_compare_value_i > counter_value_i);
    assign cmp_lt_cnt  = (ch1_compare_value_i < counter_value_i);
    // Up: high while compare above count; down: low while compare below count
    assign pwm_a_level = count_down_i ? ~cmp_lt_cnt : cmp_gt_cnt;

    always @* begin
        level_nxt_o = level_i;
        case (ch1_output_mode_field_i)
            `TCM_OM_DISCONNECT:    level_nxt_o = level_i;
            `TCM_OM_HIGH_ON_MATCH: if (match_o) level_nxt_o = 1'b1;
            `TCM_OM_LOW_ON_MATCH:  if (match_o) level_nxt_o = 1'b0;
            `TCM_OM_TOGGLE:        if (match_o) level_nxt_o = ~level_i;
            `TCM_OM_FORCE_LOW:     level_nxt_o = 1'b0;
            `TCM_OM_FORCE_HIGH:    level_nxt_o = 1'b1;
            `TCM_OM_PWM_A:         level_nxt_o = pwm_a_level;
            // Up: low while compare above count; down: complement of mode A
            `TCM_OM_PWM_B:         level_nxt_o = count_down_i ? ~pwm_a_level
                                                              : ~cmp_gt_cnt;
            default:               level_nxt_o = level_i;
        endcase
    end
endmodule

/* File: hw/tcm_ch2_select.v */
// Channel-2 direction decode and input source multiplexer.
// Assumes the filtered signals and trigger come from the timer's own clock.
`timescale 1ns/1ps
`include "tcm_defines.vh"

module tcm_ch2_select (
    input  wire [1:0] ch2_direction_select_i,
    input  wire       ch2_filtered_signal_i,
    input  wire       ch1_filtered_signal_to_ch2_i,
    input  wire       slave_trigger_input_i,
    input  wire       trigger_internal_i,
    output reg        ch2_input_source_o,
    output wire       ch2_is_input_o,
    output wire       trig_mode_bad_o
);
    assign ch2_is_input_o  = (ch2_direction_select_i != `TCM_DIR_OUTPUT);
    // Trigger-mapped input only works with an internal trigger source
    assign trig_mode_bad_o = (ch2_direction_select_i == `TCM_DIR_IN_TRIG)
                             && !trigger_internal_i;

    always @* begin
        ch2_input_source_o = 1'b0;
        case (ch2_direction_select_i)
            `TCM_DIR_OUTPUT: ch2_input_source_o = 1'b0;
            `TCM_DIR_IN_OWN: ch2_input_source_o = ch2_filtered_signal_i;
            `TCM_DIR_IN_CH1: ch2_input_source_o = ch1_filtered_signal_to_ch2_i;
            `TCM_DIR_IN_TRIG: ch2_input_source_o = trigger_internal_i
                                                   & slave_trigger_input_i;
            default:         ch2_input_source_o = 1'b0;
        endcase
    end
endmodule

/* File: tb/tcm_top_properties.sv */
// Concurrent checks on the ports of the channel mode control block.
// Assumes the register map of tcm_defines.vh; mirrors register writes itself.
`timescale 1ns/1ps
`include "tcm_defines.vh"

module tcm_top_properties (
    input wire        clock_i,
    input wire        resetn_i,
    input wire [7:0]  reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire        reg_write_i,
    input wire        reg_read_i,
    input wire [31:0] reg_rdata_o,
    input wire [15:0] counter_value_i,
    input wire        count_down_i,
    input wire        ch2_filtered_signal_i,
    input wire        ch1_filtered_signal_to_ch2_i,
    input wire        slave_trigger_input_i,
    input wire        ch1_raw_compare_level_o,
    input wire        ch1_final_output_o,
    input wire        ch1_output_connected_o,
    input wire        ch2_input_source_o,
    input wire        ch2_is_input_o
);
    reg  [2:0]  mode_q;
    reg  [1:0]  dir_q;
    reg         pol_q;
    reg         en_q;
    reg  [2:0]  tsel_q;
    reg  [15:0] cmp_q;
    wire        hit     = counter_value_i == cmp_q;
    wire        pwm_a   = count_down_i ? !(cmp_q < counter_value_i) : (cmp_q > counter_value_i);
    wire        trig_ok = slave_trigger_input_i & (tsel_q < `TCM_TRIG_INTERNAL_LIM);
    wire        raw     = ch1_raw_compare_level_o;

    // Shadow of the registers that steer the channel paths
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            {mode_q, dir_q, pol_q, en_q, tsel_q, cmp_q} <= 26'h0;
        end else if (reg_write_i) begin
            case (reg_addr_i)
                `TCM_OFS_MODE: begin
                    mode_q <= reg_wdata_i[6:4];
                    dir_q  <= en_q ? dir_q : reg_wdata_i[9:8];
                end
                `TCM_OFS_CTRL: {tsel_q, en_q, pol_q} <= {reg_wdata_i[6:4], reg_wdata_i[1:0]};
                `TCM_OFS_CMP:  cmp_q <= reg_wdata_i[15:0];
                default:       cmp_q <= cmp_q;
            endcase
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_detached_hold: assert property (mode_q == 3'h0 |=> $stable(raw)
        && !ch1_output_connected_o && ch1_final_output_o == $past(pol_q))
        else $error("mode 0 output not detached");
    a_high_on_match: assert property (mode_q == 3'h1 && hit |=> raw)
        else $error("raw not high after match");
    a_low_on_match: assert property (mode_q == 3'h2 && hit |=> !raw)
        else $error("raw not low after match");
    a_toggle_match: assert property (mode_q == 3'h3 && hit |=> raw != $past(raw))
        else $error("raw did not toggle on match");
    a_forced_level: assert property (mode_q[2:1] == 2'h2 |=> raw == $past(mode_q[0]))
        else $error("forced level wrong");
    a_pwm_a_level: assert property (mode_q == 3'h6 |=> raw == $past(pwm_a))
        else $error("pwm a level wrong");
    a_pwm_b_level: assert property (mode_q == 3'h7 |=> raw != $past(pwm_a))
        else $error("pwm b level wrong");
    a_final_route: assert property (mode_q != 3'h0 |=> ch1_output_connected_o
        && ch1_final_output_o == (raw ^ $past(pol_q)))
        else $error("final output not raw with polarity");
    a_ch2_ch1_src: assert property (dir_q == 2'h2 |=> ch2_is_input_o
        && ch2_input_source_o == $past(ch1_filtered_signal_to_ch2_i))
        else $error("channel 2 not fed from channel 1");
    a_ch2_trig_src: assert property (dir_q == 2'h3 |=> ch2_is_input_o
        && ch2_input_source_o == $past(trig_ok))
        else $error("channel 2 trigger source wrong");
    a_ch2_own_out: assert property (dir_q[1] == 1'b0 |=>
        ch2_is_input_o == $past(dir_q[0])
        && ch2_input_source_o == ($past(dir_q[0]) & $past(ch2_filtered_signal_i)))
        else $error("channel 2 output or own input wrong");
    a_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its cycle");

    c_toggle: cover property (mode_q == 3'h3 && hit);
    c_pwm_down: cover property (mode_q == 3'h7 && count_down_i);
    c_trig_ext: cover property (dir_q == 2'h3 && !(tsel_q < `TCM_TRIG_INTERNAL_LIM));
endmodule

bind tcm_top tcm_top_properties tcm_top_properties_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .counter_value_i(counter_value_i), .count_down_i(count_down_i),
    .ch2_filtered_signal_i(ch2_filtered_signal_i),
    .ch1_filtered_signal_to_ch2_i(ch1_filtered_signal_to_ch2_i),
    .slave_trigger_input_i(slave_trigger_input_i),
    .ch1_raw_compare_level_o(ch1_raw_compare_level_o), .ch1_final_output_o(ch1_final_output_o),
    .ch1_output_connected_o(ch1_output_connected_o), .ch2_input_source_o(ch2_input_source_o),
    .ch2_is_input_o(ch2_is_input_o)
);

/* File: tb/tcm_top_tb.sv */
// Self-checking bench for the channel mode control block.
// Assumes the register map of tcm_defines.vh and one 200 MHz clock.
`timescale 1ns/1ps
`include "tcm_defines.vh"

module tcm_top_tb;
    reg         clock_i = 1'b0;
    reg         resetn_i = 1'b0;
    reg  [7:0]  reg_addr_i = 8'h00;
    reg  [31:0] reg_wdata_i = 32'h0;
    reg         reg_write_i = 1'b0;
    reg         reg_read_i = 1'b0;
    reg  [15:0] counter_value_i = 16'h0100;
    reg         count_down_i = 1'b0;
    reg         ch2_filtered_signal_i = 1'b0;
    reg         ch1_filtered_signal_to_ch2_i = 1'b0;
    reg         slave_trigger_input_i = 1'b0;
    wire [31:0] reg_rdata_o;
    wire        raw, fin, conn, src, isin;
    integer     mismatches = 0;
    integer     tests_run = 0;
    integer     m, d, c, p;
    reg         pol = 1'b0;
    reg         dis = 1'b0;
    reg         exp;

    always #2.5 clock_i = ~clock_i;

    tcm_top tcm_top_i (
        .clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .counter_value_i(counter_value_i),
        .count_down_i(count_down_i), .ch2_filtered_signal_i(ch2_filtered_signal_i),
        .ch1_filtered_signal_to_ch2_i(ch1_filtered_signal_to_ch2_i),
        .slave_trigger_input_i(slave_trigger_input_i), .ch1_raw_compare_level_o(raw),
        .ch1_final_output_o(fin), .ch1_output_connected_o(conn),
        .ch2_input_source_o(src), .ch2_is_input_o(isin)
    );

    task end_sim;
        begin
            $display("compares=%0d mismatches=%0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] want);
        begin
            tests_run = tests_run + 1;
            if (got !== want) begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
            end
        end
    endtask

    task wr(input [7:0] a, input [31:0] v);
        begin
            @(posedge clock_i);
            reg_addr_i  <= a;
            reg_wdata_i <= v;
            reg_write_i <= 1'b1;
            @(posedge clock_i);
            reg_write_i <= 1'b0;
        end
    endtask

    task rd(input [7:0] a, input [31:0] want);
        begin
            @(posedge clock_i);
            reg_addr_i <= a;
            reg_read_i <= 1'b1;
            @(posedge clock_i);
            reg_read_i <= 1'b0;
            #1 chk(reg_rdata_o, want);
        end
    endtask

    // Counter shows cnt at exactly one sampling edge, then raw and final are checked
    task pulse(input [15:0] cnt, input dn, input want);
        begin
            @(posedge clock_i);
            counter_value_i <= cnt;
            count_down_i    <= dn;
            @(posedge clock_i);
            counter_value_i <= 16'h0100;
            #1 chk(raw, want);
            chk(fin, (want & ~dis) ^ pol);
            chk(conn, !dis);
        end
    endtask

    initial begin
        #20000;
        mismatches = mismatches + 1;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge clock_i);
        resetn_i <= 1'b1;
        #1 chk({raw, fin, conn, src, isin}, 32'h0);
        rd(`TCM_OFS_MODE, 32'h0);
        wr(`TCM_OFS_CMP, 32'h5);
        wr(`TCM_OFS_MODE, 32'h10);
        pulse(16'h3, 1'b0, 1'b0);
        pulse(16'h5, 1'b0, 1'b1);
        pulse(16'h6, 1'b0, 1'b1);
        wr(`TCM_OFS_MODE, 32'h20);
        pulse(16'h5, 1'b0, 1'b0);
        wr(`TCM_OFS_MODE, 32'h30);
        pulse(16'h5, 1'b0, 1'b1);
        pulse(16'h4, 1'b0, 1'b1);
        pulse(16'h5, 1'b0, 1'b0);
        wr(`TCM_OFS_MODE, 32'h40);
        pulse(16'h9, 1'b0, 1'b0);
        wr(`TCM_OFS_MODE, 32'h50);
        pulse(16'h5, 1'b0, 1'b1);
        pol = 1'b1;
        wr(`TCM_OFS_CTRL, 32'h1);
        pulse(16'h9, 1'b0, 1'b1);
        dis = 1'b1;
        wr(`TCM_OFS_MODE, 32'h0);
        pulse(16'h5, 1'b0, 1'b1);
        pol = 1'b0;
        wr(`TCM_OFS_CTRL, 32'h0);
        pulse(16'h5, 1'b0, 1'b1);
        dis = 1'b0;
        for (m = 6; m < 8; m = m + 1) begin
            wr(`TCM_OFS_MODE, m << 4);
            for (d = 0; d < 2; d = d + 1) begin
                for (c = 4; c < 7; c = c + 1) begin
                    exp = d ? (c <= 5) : (c < 5);
                    pulse(c[15:0], d[0], exp ^ (m == 7));
                end
            end
        end
        for (d = 0; d < 4; d = d + 1) begin
            wr(`TCM_OFS_MODE, d << 8);
            for (p = 0; p < 8; p = p + 1) begin
                @(posedge clock_i);
                {slave_trigger_input_i, ch1_filtered_signal_to_ch2_i,
                 ch2_filtered_signal_i} <= p[2:0];
                @(posedge clock_i);
                #1 chk(src, ({p[2:0], 1'b0} >> d) & 4'h1);
                chk(isin, d != 0);
            end
        end
        wr(`TCM_OFS_CTRL, 32'h40);
        @(posedge clock_i);
        #1 chk(src, 32'h0);
        wr(`TCM_OFS_CTRL, 32'h2);
        wr(`TCM_OFS_MODE, 32'h320);
        rd(`TCM_OFS_MODE, 32'h320);
        wr(`TCM_OFS_CTRL, 32'h0);
        wr(`TCM_OFS_MODE, 32'h120);
        rd(`TCM_OFS_MODE, 32'h120);
        // Eight compare-driven matches so far; raw, final, sticky and own input high
        rd(`TCM_OFS_STATUS, 32'hF);
        rd(`TCM_OFS_MATCH_CNT, 32'h8);
        wr(`TCM_OFS_STATUS, 32'h4);
        rd(`TCM_OFS_STATUS, 32'hB);
        wr(`TCM_OFS_MATCH_CNT, 32'h0);
        rd(`TCM_OFS_MATCH_CNT, 32'h0);
        rd(8'h20, 32'h0);
        end_sim;
    end
endmodule
